// ### rtl/hdtrc_consts.svh
`ifndef HDTRC_CONSTS_SVH
`define HDTRC_CONSTS_SVH
`define HDTRC_WORD_ONES      10'h3ff
`define HDTRC_WORD_ZERO      10'h000
`define HDTRC_LINE_FIRST     11'h001
`define HDTRC_LINE_LAST      11'h465
`define HDTRC_I_F1_VB_END    11'h014
`define HDTRC_I_F1_ACT_END   11'h230
`define HDTRC_I_F1_END       11'h233
`define HDTRC_I_F2_VB_END    11'h247
`define HDTRC_I_F2_ACT_END   11'h463
`define HDTRC_P_VB_END       11'h029
`define HDTRC_P_ACT_END      11'h461
`define HDTRC_ACT_LINES      11'h438
`define HDTRC_ACT_SAMPLES    12'h780
`define HDTRC_CODE_LEN       12'h004
`define HDTRC_LINE_LEN_DEF   12'h898
`define HDTRC_LINE_LEN_MID   12'ha50
`define HDTRC_LINE_LEN_LONG  12'habe
`define HDTRC_PROT_TABLE     32'h1ca76bd0
`define HDTRC_BIT_FIXED      9
`define HDTRC_BIT_F          8
`define HDTRC_BIT_V          7
`define HDTRC_BIT_H          6
`define HDTRC_PROT_HI        5
`define HDTRC_PROT_LO        2
`endif

// ### rtl/hdtrc_pkg.sv
package hdtrc_pkg;
    typedef enum logic [1:0] {HDTRC_SCAN_INTERLACE, HDTRC_SCAN_PROGRESSIVE} hdtrc_scan_type;
    typedef enum {HDTRC_TX_IDLE, HDTRC_TX_CODE} hdtrc_tx_type;
    typedef enum {HDTRC_RX_W0, HDTRC_RX_W1, HDTRC_RX_W2, HDTRC_RX_W3} hdtrc_rx_type;
endpackage

// ### rtl/hdtrc_top.sv
// What this block does
// - Each code is four words: all ones, then zero, then zero, then the flag word.
// - Flag word: bit9 one, F bit8, V bit7, H bit6, protection bits 5..2, bits 1..0 zero.
// - Eight-bit paths carry word bits nine down to two only.
// - H is one in end code, zero in start code; V one during vertical blanking.
// - F is one in field two, zero in field one, always zero when progressive.
// - F and V change only at the end code starting a line.
// - Protection bits come from the fixed F,V,H table.
// - Receiver corrects single errors and flags double errors in the top eight bits.
// - Flag state as a number has F as MSB and H as LSB.
// - Each frame has exactly 1080 active lines.
// - Interlace field one spans lines 1..563, active 21..560.
// - Interlace field two spans lines 564..1125, active 584..1123.
// - Interlace V is one on lines 1..20, 561..583, 1124..1125.
// - Progressive blanking on lines 1..41 and 1122..1125, active 42..1121.
// - Line counter runs 1..1125 and wraps to 1.
// - A code precedes and follows each data block on every line.
// - Lines last 2200, 2640 or 2750 samples with 1920 active samples.
`timescale 1ns/1ps
`include "hdtrc_consts.svh"
module hdtrc_top import hdtrc_pkg::*; #(
    parameter logic [11:0] LINE_LEN = `HDTRC_LINE_LEN_DEF
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic scan_progressive,
    input wire logic [9:0] rx_word,
    output logic [9:0] tx_word_r,
    output logic tx_code_r,
    output logic tx_active_r,
    output logic [10:0] tx_line_r,
    output logic [2:0] rx_fvh_r,
    output logic rx_code_r,
    output logic rx_corrected_r,
    output logic rx_error_r
);
    // Only the three line lengths keep the code positions meaningful
    if (LINE_LEN != `HDTRC_LINE_LEN_DEF && LINE_LEN != `HDTRC_LINE_LEN_MID
        && LINE_LEN != `HDTRC_LINE_LEN_LONG) begin : g_len_check
        $error("LINE_LEN must be 2200, 2640 or 2750");
    end

    // --------------------------------------------------------------
    // Protection table
    // --------------------------------------------------------------
    function automatic logic [3:0] prot_of(input logic [2:0] fvh);
        logic [3:0] p;
        p = {fvh[1] ^ fvh[0], fvh[2] ^ fvh[0], fvh[2] ^ fvh[1], fvh[2] ^ fvh[1] ^ fvh[0]};
        return p;
    endfunction

    function automatic logic [9:0] flag_word(input logic [2:0] fvh);
        logic [9:0] w;
        w = {1'b1, fvh, prot_of(fvh), 2'b00};
        return w;
    endfunction

    // --------------------------------------------------------------
    // Transmit timing
    // --------------------------------------------------------------
    // Line layout: EAV at 0..3, blanking, SAV at the last four samples before active video
    logic [11:0] samp_r;
    logic [11:0] samp_nxt;
    logic [10:0] line_nxt;
    logic [11:0] sav_start;
    logic [11:0] act_start;
    logic line_end;
    logic f_r;
    logic v_r;
    logic f_nxt;
    logic v_nxt;
    logic prog_r;
    logic [2:0] scan_sync_r;
    logic scan_prog_r;

    // Mode pin may come from another domain; it counts once two late stages agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scan_sync_r <= 3'h0;
            scan_prog_r <= 1'b0;
        end else if (clk_en) begin
            scan_sync_r <= {scan_sync_r[1:0], scan_progressive};
            if (scan_sync_r[2] == scan_sync_r[1]) begin
                scan_prog_r <= scan_sync_r[2];
            end
        end
    end

    assign act_start = LINE_LEN - `HDTRC_ACT_SAMPLES;
    assign sav_start = act_start - `HDTRC_CODE_LEN;
    assign line_end = (samp_r == LINE_LEN - 12'h001);
    assign samp_nxt = line_end ? 12'h000 : samp_r + 12'h001;
    assign line_nxt = (tx_line_r == `HDTRC_LINE_LAST) ? `HDTRC_LINE_FIRST
                      : tx_line_r + 11'h001;

    always_comb begin
        // Flags of the new line follow the mode that line will run in
        if (scan_prog_r) begin
            f_nxt = 1'b0;
            v_nxt = (line_nxt <= `HDTRC_P_VB_END) || (line_nxt > `HDTRC_P_ACT_END);
        end else begin
            f_nxt = (line_nxt > `HDTRC_I_F1_END);
            v_nxt = (line_nxt <= `HDTRC_I_F1_VB_END)
                    || (line_nxt > `HDTRC_I_F1_ACT_END && line_nxt <= `HDTRC_I_F2_VB_END)
                    || (line_nxt > `HDTRC_I_F2_ACT_END);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            samp_r <= 12'h000;
            tx_line_r <= `HDTRC_LINE_FIRST;
            f_r <= 1'b0;
            v_r <= 1'b1;
            prog_r <= 1'b0;
        end else if (clk_en) begin
            samp_r <= samp_nxt;
            if (line_end) begin
                // Scan mode is taken only at a line boundary so flags never glitch
                prog_r <= scan_prog_r;
                tx_line_r <= line_nxt;
                f_r <= f_nxt;
                v_r <= v_nxt;
            end
        end
    end

    // Word emitted for the current sample; flags of sample 0 already hold the new line
    logic [9:0] word_nxt;
    logic code_nxt;
    logic [11:0] sub;
    always_comb begin
        word_nxt = `HDTRC_WORD_ZERO;
        code_nxt = 1'b0;
        sub = 12'h000;
        if (samp_r < `HDTRC_CODE_LEN) begin
            sub = samp_r;
            code_nxt = 1'b1;
        end else if (samp_r >= sav_start && samp_r < act_start) begin
            sub = samp_r - sav_start;
            code_nxt = 1'b1;
        end
        if (code_nxt) begin
            case (sub[1:0])
                2'd0: word_nxt = `HDTRC_WORD_ONES;
                2'd3: word_nxt = flag_word({f_r, v_r, samp_r < `HDTRC_CODE_LEN});
                default: word_nxt = `HDTRC_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_word_r <= `HDTRC_WORD_ZERO;
            tx_code_r <= 1'b0;
            tx_active_r <= 1'b0;
        end else if (clk_en) begin
            tx_word_r <= word_nxt;
            tx_code_r <= code_nxt;
            tx_active_r <= !v_r && samp_r >= act_start;
        end
    end

    // --------------------------------------------------------------
    // Receive decoder
    // --------------------------------------------------------------
    // Only bits 9..2 are examined so 8-bit sources decode identically
    logic [7:0] rx_hi;
    hdtrc_rx_type rx_st_r;
    assign rx_hi = rx_word[9:2];

    logic [2:0] dec_fvh;
    logic dec_ok;
    logic dec_fix;
    logic [6:0] rcv;
    logic [6:0] diff;
    logic [3:0] ones;
    always_comb begin
        rcv = rx_hi[6:0];
        dec_fvh = rcv[6:4];
        dec_ok = 1'b0;
        dec_fix = 1'b0;
        diff = 7'h00;
        ones = 4'h0;
        // Distance kept in four bits so eight differing bits cannot wrap to zero
        for (int c = 0; c < 8; c++) begin
            diff = rcv ^ {c[2:0], prot_of(c[2:0])};
            ones = 4'(diff[0]) + 4'(diff[1]) + 4'(diff[2]) + 4'(diff[3])
                   + 4'(diff[4]) + 4'(diff[5]) + 4'(diff[6]);
            if (!rx_hi[7]) ones = ones + 4'h1;
            if (ones <= 4'h1 && !dec_ok) begin
                dec_ok = 1'b1;
                dec_fix = (ones == 4'h1);
                dec_fvh = c[2:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_st_r <= HDTRC_RX_W0;
            rx_fvh_r <= 3'b000;
            rx_code_r <= 1'b0;
            rx_corrected_r <= 1'b0;
            rx_error_r <= 1'b0;
        end else if (clk_en) begin
            rx_code_r <= 1'b0;
            rx_corrected_r <= 1'b0;
            rx_error_r <= 1'b0;
            case (rx_st_r)
                HDTRC_RX_W1: rx_st_r <= (rx_hi == 8'h00) ? HDTRC_RX_W2
                             : (rx_hi == 8'hff) ? HDTRC_RX_W1 : HDTRC_RX_W0;
                HDTRC_RX_W2: rx_st_r <= (rx_hi == 8'h00) ? HDTRC_RX_W3
                             : (rx_hi == 8'hff) ? HDTRC_RX_W1 : HDTRC_RX_W0;
                HDTRC_RX_W3: begin
                    rx_st_r <= HDTRC_RX_W0;
                    rx_code_r <= 1'b1;
                    if (dec_ok) begin
                        rx_fvh_r <= dec_fvh;
                        rx_corrected_r <= dec_fix;
                    end else begin
                        rx_error_r <= 1'b1;
                    end
                end
                default: rx_st_r <= (rx_hi == 8'hff) ? HDTRC_RX_W1 : HDTRC_RX_W0;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    // Protection nibbles by flag value, kept apart from the XOR form above
    localparam logic [31:0] PROT_TAB = `HDTRC_PROT_TABLE;

    property p_line_wrap;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && line_end && tx_line_r == `HDTRC_LINE_LAST) |=> tx_line_r == `HDTRC_LINE_FIRST;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line did not wrap");

    property p_preamble;
        @(posedge mclk) disable iff (!resetn)
        ($rose(tx_code_r)) |-> tx_word_r == `HDTRC_WORD_ONES
            ##1 (!$past(clk_en) || tx_word_r == `HDTRC_WORD_ZERO);
    endproperty
    a_preamble: assert property (p_preamble) else $error("bad preamble");

    property p_fixed_bits;
        @(posedge mclk) disable iff (!resetn)
        (tx_code_r && tx_word_r[`HDTRC_BIT_FIXED] && tx_word_r != `HDTRC_WORD_ONES)
        |-> tx_word_r[1:0] == 2'b00
            && tx_word_r[`HDTRC_PROT_HI:`HDTRC_PROT_LO]
               == PROT_TAB[{tx_word_r[`HDTRC_BIT_F:`HDTRC_BIT_H], 2'b00} +: 4];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("bad flag word");

    property p_h_flag;
        @(posedge mclk) disable iff (!resetn)
        (tx_code_r && tx_word_r[`HDTRC_BIT_FIXED] && tx_word_r != `HDTRC_WORD_ONES)
        |-> tx_word_r[`HDTRC_BIT_H] == (samp_r == `HDTRC_CODE_LEN);
    endproperty
    a_h_flag: assert property (p_h_flag) else $error("H flag on wrong code");

    property p_active_gap;
        @(posedge mclk) disable iff (!resetn)
        tx_active_r |-> !tx_code_r && tx_word_r == `HDTRC_WORD_ZERO;
    endproperty
    a_active_gap: assert property (p_active_gap) else $error("code inside active video");

    property p_prog_v;
        @(posedge mclk) disable iff (!resetn)
        prog_r |-> v_r == (tx_line_r <= `HDTRC_P_VB_END || tx_line_r > `HDTRC_P_ACT_END);
    endproperty
    a_prog_v: assert property (p_prog_v) else $error("progressive V wrong");

    property p_rx_hold;
        @(posedge mclk) disable iff (!resetn)
        rx_error_r |-> $stable(rx_fvh_r);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("flags moved on bad code");

    property p_prog_f;
        @(posedge mclk) disable iff (!resetn)
        prog_r |-> !f_r;
    endproperty
    a_prog_f: assert property (p_prog_f) else $error("F set in progressive");

    property p_fv_stable;
        @(posedge mclk) disable iff (!resetn)
        (samp_r != 12'h000) |-> $stable(f_r) && $stable(v_r);
    endproperty
    a_fv_stable: assert property (p_fv_stable) else $error("F or V moved mid-line");

    property p_int_vb;
        @(posedge mclk) disable iff (!resetn)
        (!prog_r && tx_line_r == `HDTRC_I_F1_VB_END + 11'h001) |-> !v_r && !f_r;
    endproperty
    a_int_vb: assert property (p_int_vb) else $error("line 21 not active");

    property p_f2;
        @(posedge mclk) disable iff (!resetn)
        (!prog_r && tx_line_r == `HDTRC_I_F1_END + 11'h001 && samp_r != 12'h000) |-> f_r && v_r;
    endproperty
    a_f2: assert property (p_f2) else $error("line 564 wrong flags");

    property p_rx_err;
        @(posedge mclk) disable iff (!resetn)
        rx_error_r |-> rx_code_r && !rx_corrected_r;
    endproperty
    a_rx_err: assert property (p_rx_err) else $error("error without code");

    c_eav: cover property (@(posedge mclk) disable iff (!resetn) $rose(tx_code_r) && samp_r == 12'h001);
    c_wrap: cover property (@(posedge mclk) disable iff (!resetn) tx_line_r == `HDTRC_LINE_LAST);
    c_fix: cover property (@(posedge mclk) disable iff (!resetn) rx_corrected_r);
    c_err: cover property (@(posedge mclk) disable iff (!resetn) rx_error_r);
endmodule // hdtrc_top

// ### test/hdtrc_stream_src.sv
`timescale 1ns/1ps
// ----
// Far-end stream source
// ----
module hdtrc_stream_src (
    input wire logic mclk,
    output logic [9:0] rx_word
);
    function automatic logic [9:0] flag_word(input logic [2:0] fvh);
        logic [3:0] prot [8];
        prot = '{4'h0, 4'hd, 4'hb, 4'h6, 4'h7, 4'ha, 4'hc, 4'h1};
        return {1'b1, fvh, prot[fvh], 2'b00};
    endfunction
    // Flip mask lets a scenario damage the flag word on purpose
    task automatic send_code(input logic [2:0] fvh, input logic [9:0] flip);
        logic [9:0] words [4];
        words = '{10'h3ff, 10'h000, 10'h000, flag_word(fvh) ^ flip};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1 rx_word = words[i];
        end
    endtask
    initial rx_word = 10'h155;
endmodule // hdtrc_stream_src

// ### test/hdtrc_top_tb_top.sv
`timescale 1ns/1ps
// ----
// Bench top
// ----
module hdtrc_top_tb_top;
    localparam logic [11:0] LL = 12'h898;
    logic mclk, resetn, clk_en, scan_progressive;
    logic [9:0] rx_word, tx_word_r;
    logic tx_code_r, tx_active_r, rx_code_r, rx_corrected_r, rx_error_r;
    logic [10:0] tx_line_r;
    logic [2:0] rx_fvh_r;
    int fails = 0, comparisons = 0, cyc = 0, code_at = 0, eav_at = 0;
    hdtrc_top #(.LINE_LEN(LL)) u_hdtrc_top (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .scan_progressive(scan_progressive), .rx_word(rx_word), .tx_word_r(tx_word_r),
        .tx_code_r(tx_code_r), .tx_active_r(tx_active_r), .tx_line_r(tx_line_r),
        .rx_fvh_r(rx_fvh_r), .rx_code_r(rx_code_r), .rx_corrected_r(rx_corrected_r),
        .rx_error_r(rx_error_r));
    hdtrc_stream_src u_hdtrc_stream_src (.mclk(mclk), .rx_word(rx_word));
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Generous ceiling: 23 lines plus the receive cases
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_code(input logic [2:0] fvh);
        int n;
        n = 0;
        while (tx_code_r !== 1'b1 && n < 3000) begin
            @(posedge mclk); #1;
            n++;
        end
        code_at = cyc;
        chk("word0", 12'h3ff, {2'b00, tx_word_r});
        for (int i = 1; i < 4; i++) begin
            @(posedge mclk); #1;
            chk("code_word", {2'b00, i < 3 ? 10'h000 : u_hdtrc_stream_src.flag_word(fvh)},
                {2'b00, tx_word_r});
        end
    endtask
    task automatic run_line(input int ln);
        logic v;
        int n, act;
        v = (ln <= 20) || (ln >= 22);
        check_code({1'b0, v, 1'b1});
        chk("line", 12'(ln), {1'b0, tx_line_r});
        if (ln > 1) chk("line_len", LL + (ln == 23 ? 12'h00a : 12'h000), 12'(code_at - eav_at));
        eav_at = code_at;
        // Step off the end code's last word before looking for the start code
        @(posedge mclk); #1;
        check_code({1'b0, v, 1'b0});
        if (ln == 21) scan_progressive = 1;
        if (ln == 22) begin
            // Frozen edges must not advance the sample count
            clk_en = 0;
            repeat (10) @(posedge mclk);
            #1 clk_en = 1;
        end
        n = 0;
        act = 0;
        do begin
            @(posedge mclk); #1;
            n++;
            if (tx_active_r === 1'b1) act++;
        end while (tx_code_r !== 1'b1 && n < 3000);
        chk("active", ln == 21 ? 12'h780 : 12'h000, 12'(act));
    endtask
    task automatic rx_case(input logic [2:0] fvh, input logic [9:0] flip, input logic [2:0] ef,
                           input logic ec, input logic ee);
        int n;
        u_hdtrc_stream_src.send_code(fvh, flip);
        n = 0;
        do begin
            @(posedge mclk); #1;
            n++;
        end while (rx_code_r !== 1'b1 && n < 4);
        chk("rx_code", 12'h001, {11'h000, rx_code_r});
        chk("rx_corr", {11'h000, ec}, {11'h000, rx_corrected_r});
        chk("rx_err", {11'h000, ee}, {11'h000, rx_error_r});
        chk("rx_fvh", {9'h000, ef}, {9'h000, rx_fvh_r});
    endtask
    initial begin
        resetn = 0;
        clk_en = 1;
        scan_progressive = 0;
        repeat (20) @(posedge mclk);
        #1 resetn = 1;
        for (int ln = 1; ln <= 23; ln++) run_line(ln);
        for (int f = 0; f < 8; f++) begin
            rx_case(3'(f), 10'h000, 3'(f), 1'b0, 1'b0);
            rx_case(3'(f), 10'h004 << f, 3'(f), 1'b1, 1'b0);
            rx_case(3'(f), 10'h003, 3'(f), 1'b0, 1'b0);
        end
        rx_case(3'h3, 10'h180, 3'h7, 1'b0, 1'b1);
        @(posedge mclk); #1 resetn = 0;
        @(posedge mclk); #1;
        chk("reset_line", 12'h001, {1'b0, tx_line_r});
        chk("reset_fvh", 12'h000, {9'h000, rx_fvh_r});
        resetn = 1;
        complete_run();
    end
endmodule // hdtrc_top_tb_top
